// ### include/qdac_map.svh
// Constants of the quad converter serial load block
//
// Operation
// [R01] One transfer carries a sixteen-bit word
// [R02] Host sends most significant bit first
// [R03] Shift one bit per serial clock rise
// [R04] Shifting only while chip select low
// [R05] Only last sixteen bits count at load
// [R06] Byte hosts keep select low between bytes
// [R07] Select rise loads addressed input register
// [R08] Four channels, input and output registers
// [R09] Strobe copies inputs to all outputs together
// [R10] Preset forces zero or half scale
// [R11] Power-up reset forces zero or half scale
// [R12] Preset values hold until a word loads
// [R13] Preset may be tied inactive high
// [R14] Bits 15..14 address, 13..0 code
// [R15] Address 00..11 selects channel one..four
// [R16] Strobe low transparent, high holds outputs
// [R17] Half scale value is 2000h
// [R18] Preset overrides loads and strobe while held
`ifndef QDAC_MAP_SVH
`define QDAC_MAP_SVH
`define QDAC_WORD_W    16
`define QDAC_CODE_W    14
`define QDAC_CHAN_N    4
`define QDAC_ADDR_HI   15
`define QDAC_ADDR_LO   14
`define QDAC_CODE_HI   13
`define QDAC_ZERO_CODE 14'h0000
`define QDAC_HALF_CODE 14'h2000
`define QDAC_FIFO_DEP  16
`define QDAC_INIT_CYC  2'h3
`define QDAC_PIN_IDLE  6'h19
`endif

// ### include/qdac_pkg.sv
// Types shared by the quad converter serial load block
`include "qdac_map.svh"
package qdac_pkg;
  typedef logic [`QDAC_CODE_W-1:0] qdac_code_t;
  typedef struct packed {
    logic [1:0] chan;
    qdac_code_t code;
  } qdac_word_t;
  typedef enum logic [0:0] {QDAC_INIT, QDAC_RUN} qdac_state_t;
endpackage : qdac_pkg

// ### rtl/qdac_fifo.sv
// Word FIFO between the serial front end and the input registers
`timescale 1ns/10ps
`default_nettype none
module qdac_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wrPtr_ff;
  logic [AW-1:0]    rdPtr_ff;
  logic [AW:0]      count_ff;
  logic             doPush;
  logic             doPop;

  assign inReady  = (count_ff != (AW+1)'(DEPTH));
  assign outValid = (count_ff != '0);
  assign outData  = mem_ff[rdPtr_ff];
  assign doPush   = inValid && inReady && !flush;
  assign doPop    = outValid && outReady && !flush;

  always_ff @(posedge clk) begin
    if (doPush) begin
      mem_ff[wrPtr_ff] <= inData;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else if (flush) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (doPush) begin
        wrPtr_ff <= AW'(wrPtr_ff + 1'b1);
      end
      if (doPop) begin
        rdPtr_ff <= AW'(rdPtr_ff + 1'b1);
      end
      if (doPush && !doPop) begin
        count_ff <= (AW+1)'(count_ff + 1'b1);
      end else if (doPop && !doPush) begin
        count_ff <= (AW+1)'(count_ff - 1'b1);
      end
    end
  end
endmodule : qdac_fifo
`default_nettype wire

// ### rtl/qdac_serial_load.sv
// Serial load front end of the quad fourteen-bit converter
`timescale 1ns/10ps
`default_nettype none
`include "qdac_map.svh"
module qdac_serial_load (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     chipSelN,
  input  wire logic                     serialClk,
  input  wire logic                     serialIn,
  input  wire logic                     load_outputs_strobe_n,
  input  wire logic                     preset_n,
  input  wire logic                     levelSel,
  output logic [`QDAC_CHAN_N-1:0][`QDAC_CODE_W-1:0] chanCode,
  output logic                          serial_chain_out,
  output logic                          wordDropped
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [5:0] syncA_ff;
  logic [5:0] syncB_ff;
  logic       csN;
  logic       sclk;
  logic       sdi;
  logic       strobeN;
  logic       presetN;
  logic       level;

  // All pins idle high except clock, data and level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_ff <= `QDAC_PIN_IDLE;
      syncB_ff <= `QDAC_PIN_IDLE;
    end else begin
      syncA_ff <= {levelSel, preset_n, load_outputs_strobe_n,
                   serialIn, serialClk, chipSelN};
      syncB_ff <= syncA_ff;
    end
  end

  assign csN     = syncB_ff[0];
  assign sclk    = syncB_ff[1];
  assign sdi     = syncB_ff[2];
  assign strobeN = syncB_ff[3];
  assign presetN = syncB_ff[4];
  assign level   = syncB_ff[5];

  function automatic qdac_pkg::qdac_code_t presetCode(input logic lvl);
    presetCode = lvl ? `QDAC_HALF_CODE : `QDAC_ZERO_CODE; // [R17]
  endfunction : presetCode

  // ****************************************
  // Edge detection
  // ****************************************
  logic sclkPrev_ff;
  logic csPrev_ff;
  logic sclkRise;
  logic csRise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclkPrev_ff <= 1'b0;
      csPrev_ff   <= 1'b1;
    end else begin
      sclkPrev_ff <= sclk;
      csPrev_ff   <= csN;
    end
  end

  assign sclkRise = sclk && !sclkPrev_ff;
  assign csRise   = csN && !csPrev_ff;

  // ****************************************
  // Serial shift register
  // ****************************************
  logic [`QDAC_WORD_W-1:0] shift_ff;
  logic                    chainOut_ff;

  // Older bits fall off the top, so the last sixteen remain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_ff <= '0;
    end else if (sclkRise && !csN) begin // [R04]
      shift_ff <= {shift_ff[`QDAC_WORD_W-2:0], sdi}; // [R01] [R03] [R05]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      chainOut_ff <= 1'b0;
    end else if (sclkRise && !csN) begin
      chainOut_ff <= shift_ff[`QDAC_WORD_W-1];
    end
  end

  // ****************************************
  // Control state
  // ****************************************
  qdac_pkg::qdac_state_t state_ff;
  logic [1:0]            initCnt_ff;
  logic                  forcePreset;

  // Level pin is only valid after its synchroniser has filled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= qdac_pkg::QDAC_INIT;
      initCnt_ff <= 2'h0;
    end else begin
      unique case (state_ff)
        qdac_pkg::QDAC_INIT: begin
          initCnt_ff <= 2'(initCnt_ff + 1'b1);
          if (initCnt_ff == `QDAC_INIT_CYC - 2'h1) begin
            state_ff <= qdac_pkg::QDAC_RUN;
          end
        end
        qdac_pkg::QDAC_RUN: begin
          initCnt_ff <= initCnt_ff;
        end
      endcase
    end
  end

  assign forcePreset = !presetN || (state_ff == qdac_pkg::QDAC_INIT); // [R11] [R18]

  // ****************************************
  // Word FIFO
  // ****************************************
  qdac_pkg::qdac_word_t pushWord;
  qdac_pkg::qdac_word_t popWord;
  logic                 pushReady;
  logic                 popValid;
  logic                 dropped_ff;

  assign pushWord.chan = shift_ff[`QDAC_ADDR_HI:`QDAC_ADDR_LO]; // [R14]
  assign pushWord.code = shift_ff[`QDAC_CODE_HI:0]; // [R14]

  // Preset flushes queued words so none lands after release
  qdac_fifo #(
    .WIDTH ($bits(qdac_pkg::qdac_word_t)),
    .DEPTH (`QDAC_FIFO_DEP)
  ) uFifo (
    .clk      (clk),
    .rst_n    (rst_n),
    .flush    (forcePreset),
    .inData   (pushWord),
    .inValid  (csRise),
    .inReady  (pushReady),
    .outData  (popWord),
    .outValid (popValid),
    .outReady (!forcePreset)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dropped_ff <= 1'b0;
    end else begin
      dropped_ff <= csRise && (!pushReady || forcePreset);
    end
  end

  // ****************************************
  // Channel registers
  // ****************************************
  qdac_pkg::qdac_code_t inReg_ff  [`QDAC_CHAN_N];
  qdac_pkg::qdac_code_t outReg_ff [`QDAC_CHAN_N];

  for (genvar ch = 0; ch < `QDAC_CHAN_N; ch++) begin : gChan // [R08]
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        inReg_ff[ch] <= `QDAC_ZERO_CODE;
      end else if (forcePreset) begin
        inReg_ff[ch] <= presetCode(level); // [R10] [R11] [R18]
      end else if (popValid && popWord.chan == 2'(ch)) begin // [R15]
        inReg_ff[ch] <= popWord.code; // [R07] [R12]
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        outReg_ff[ch] <= `QDAC_ZERO_CODE;
      end else if (forcePreset) begin
        outReg_ff[ch] <= presetCode(level); // [R10] [R18]
      end else if (!strobeN) begin // [R16]
        outReg_ff[ch] <= inReg_ff[ch]; // [R09]
      end
    end

    assign chanCode[ch] = outReg_ff[ch];
  end

  assign serial_chain_out = chainOut_ff;
  assign wordDropped      = dropped_ff;
endmodule : qdac_serial_load
`default_nettype wire

// ### bench/qdac_serial_load_monitor.sv
// Port checker of the quad converter serial load block
`timescale 1ns/10ps
`default_nettype none
`include "qdac_map.svh"
module qdac_serial_load_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chipSelN,
  input wire logic serialClk,
  input wire logic serialIn,
  input wire logic load_outputs_strobe_n,
  input wire logic preset_n,
  input wire logic levelSel,
  input wire logic [`QDAC_CHAN_N-1:0][`QDAC_CODE_W-1:0] chanCode,
  input wire logic serial_chain_out,
  input wire logic wordDropped
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Repeat counts leave room for the input synchronisers
  chk_init_half: assert property (
    $rose(rst_n) ##0 levelSel[*6] |-> chanCode == {4{`QDAC_HALF_CODE}})
    else $error("bad init value");
  chk_preset_zero: assert property (
    (!preset_n && !levelSel)[*5] |-> chanCode == '0)
    else $error("bad zero preset");
  chk_preset_half: assert property (
    (!preset_n && levelSel)[*5] |-> chanCode == {4{`QDAC_HALF_CODE}})
    else $error("bad half preset");
  chk_strobe_hold: assert property (
    (load_outputs_strobe_n && preset_n && $past(rst_n, 8))[*4] |=> $stable(chanCode))
    else $error("outputs moved while held");
  chk_drop_pulse: assert property (
    wordDropped |=> !wordDropped)
    else $error("drop pulse too long");
  chk_drop_cause: assert property (
    wordDropped |-> $past(chipSelN, 3) && !$past(chipSelN, 4))
    else $error("drop without select rise");
  chk_chain_idle: assert property (
    (chipSelN && preset_n && $past(rst_n, 8))[*4] |=> $stable(serial_chain_out))
    else $error("shift with select high");
  chk_chain_edge: assert property (
    $changed(serial_chain_out) |-> $past(serialClk, 3) && !$past(serialClk, 4)
      && !$past(chipSelN, 3))
    else $error("shift without clock rise");
  cover property (wordDropped);
  cover property (!preset_n && levelSel);
  cover property (chipSelN ##1 !chipSelN);
endmodule : qdac_serial_load_monitor
bind qdac_serial_load qdac_serial_load_monitor mon (.clk(clk), .rst_n(rst_n),
  .chipSelN(chipSelN), .serialClk(serialClk), .serialIn(serialIn), .levelSel(levelSel),
  .load_outputs_strobe_n(load_outputs_strobe_n), .preset_n(preset_n), .chanCode(chanCode),
  .serial_chain_out(serial_chain_out), .wordDropped(wordDropped));
`default_nettype wire

// ### bench/qdac_host_model.sv
// Host model driving the three-wire link
`timescale 1ns/10ps
`default_nettype none
module qdac_host_model (
  input wire logic clk,
  output logic chipSelN,
  output logic serialClk,
  output logic serialIn
);
  initial {chipSelN, serialClk, serialIn} = 3'h4;
  task automatic halfBit(input logic c);
    repeat (8) @(posedge clk);
    serialClk <= c;
  endtask : halfBit
  // Clock rests low; data goes stale once select rises
  task automatic send(input logic [23:0] w, input int n, input logic cs);
    @(posedge clk);
    chipSelN <= cs;
    for (int i = n - 1; i >= 0; i--) begin
      serialIn <= w[i];
      halfBit(1'b1);
      halfBit(1'b0);
    end
    repeat (8) @(posedge clk);
    chipSelN <= 1'b1;
    serialIn <= ~serialIn;
    repeat (16) @(posedge clk);
  endtask : send
endmodule : qdac_host_model
`default_nettype wire

// ### bench/qdac_serial_load_tb.sv
// Self-checking bench of the quad converter serial load block
`timescale 1ns/10ps
`default_nettype none
`include "qdac_map.svh"
module qdac_serial_load_tb;
  localparam qdac_pkg::qdac_code_t HALF = `QDAC_HALF_CODE;
  localparam logic [15:0] WORDS [4] = '{16'h0123, 16'h5ABC, 16'hBFFF, 16'hC001};
  logic clk = 1'b0, rst_n = 1'b0, strobeN = 1'b1, presetN = 1'b1;
  logic levelSel = 1'b1, dropSeen = 1'b0;
  logic csN, sclk, sdi, dropped, chainOut;
  logic [`QDAC_CHAN_N-1:0][`QDAC_CODE_W-1:0] chanCode;
  int errors = 0, n_tests = 0, cycles = 0;
  always #2.5 clk = ~clk;
  qdac_host_model host (.clk(clk), .chipSelN(csN), .serialClk(sclk), .serialIn(sdi));
  qdac_serial_load dut (.clk(clk), .rst_n(rst_n), .chipSelN(csN), .serialClk(sclk),
    .serialIn(sdi), .load_outputs_strobe_n(strobeN), .preset_n(presetN),
    .levelSel(levelSel), .chanCode(chanCode), .serial_chain_out(chainOut),
    .wordDropped(dropped));
  task automatic check(input qdac_pkg::qdac_code_t seen, input qdac_pkg::qdac_code_t exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic checkAll(input qdac_pkg::qdac_code_t exp);
    for (int i = 0; i < 4; i++) check(chanCode[i], exp);
  endtask : checkAll
  task automatic give_verdict();
    if (errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // Drop pulse lasts one cycle, so latch it
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (dropped === 1'b1) dropSeen <= 1'b1;
    if (cycles == 6000) begin
      errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    checkAll(HALF);
    for (int i = 0; i < 4; i++) host.send({8'h00, WORDS[i]}, 16, 1'b0);
    checkAll(HALF);
    check({13'h0000, chainOut}, 14'h0001);
    strobeN <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 4; i++) check(chanCode[i], WORDS[i][13:0]);
    host.send(24'h3C12C5, 24, 1'b0);
    check(chanCode[0], 14'h12C5);
    check({13'h0000, chainOut}, 14'h0000);
    host.send(24'hFFFFFF, 8, 1'b1);
    host.send(24'h00003A, 8, 1'b0);
    check(chanCode[3], 14'h053A);
    check({13'h0000, dropSeen}, 14'h0000);
    presetN <= 1'b0;
    repeat (10) @(posedge clk);
    checkAll(HALF);
    levelSel <= 1'b0;
    host.send(24'h007FFF, 16, 1'b0);
    checkAll(14'h0000);
    check({13'h0000, dropSeen}, 14'h0001);
    presetN <= 1'b1;
    repeat (20) @(posedge clk);
    checkAll(14'h0000);
    give_verdict();
  end
endmodule : qdac_serial_load_tb
`default_nettype wire
